/* tb_top.sv */
// Self-checking bench of the mode, phase and slew control block
// Assumes the bound checker and the host model; minimum slew resistor keeps the run short
`timescale 1ns/1ps
`include "tpbmsc_consts.vh"

module tb_top;
  // ==========================================================
  // Signals
  localparam int BASE = 357 * 250 / 715;
  localparam logic [7:0] ST = `TPBMSC_ADDR_STATUS, IV = `TPBMSC_ADDR_INTERVAL;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [6:0]  voltage_code, target_code, goal_code;
  logic        deeper_sleep_request, power_state_hint_n, deeper_stop_hint_n, shutdown_n;
  logic        sleep_cmd, hint_cmd, stop_cmd, run_cmd, shutdown_test_level, phase2_sense_pos;
  logic        regulation_ok, overvoltage_fault, zero_cross_1, pwm_high_req_1, pwm_high_req_2, pwm_low_req_1;
  logic        high_side_drive_1, high_side_drive_2, low_side_drive_1, low_side_drive_2;
  logic        power_good_out, phase2_active, skip_mode, upper_pg_blank, ov_fixed_threshold;
  logic        protect_disable, fault_latch_clear, overlap_disable, boost_switch_off;
  logic [31:0] wv [3] = '{32'h7ff, 32'h0, 32'h165};
  logic [31:0] ev [3] = '{32'h6f4, 32'h165, 32'h165};
  int          n_fail, cmp_count, cyc, n, i;

  tpbmsc_host_model i_host (.hclk, .hresetn, .goal_code, .sleep_cmd, .hint_cmd, .stop_cmd, .run_cmd,
    .voltage_code, .deeper_sleep_request, .power_state_hint_n, .deeper_stop_hint_n, .shutdown_n);

  tpbmsc_ctrl #(.PG_HOLD_CYCLES(32'd20)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .voltage_code, .deeper_sleep_request,
    .power_state_hint_n, .deeper_stop_hint_n, .shutdown_n, .shutdown_test_level, .phase2_sense_pos,
    .regulation_ok, .overvoltage_fault, .zero_cross_1, .zero_cross_2(1'b0), .neg_limit_1(1'b0),
    .neg_limit_2(1'b0), .pwm_high_req_1, .pwm_high_req_2, .pwm_low_req_1, .pwm_low_req_2(1'b0),
    .high_side_drive_1, .high_side_drive_2, .low_side_drive_1, .low_side_drive_2, .target_code,
    .power_good_out, .phase2_active, .skip_mode, .upper_pg_blank, .ov_fixed_threshold, .protect_disable,
    .fault_latch_clear, .overlap_disable, .boost_switch_off);

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    hsize  <= `TPBMSC_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic wait_code(input logic [6:0] c);
    while (target_code !== c) @(posedge hclk);
  endtask

  task automatic step_gap(output int k);
    logic [6:0] old;
    old = target_code;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (target_code === old);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // Clock and watchdog
  always #2 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 95000) begin
      n_fail++;
      results();
    end
  end

  // ==========================================================
  // Sequence
  initial begin
    {hclk, hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
    {sleep_cmd, hint_cmd, stop_cmd, run_cmd, shutdown_test_level, phase2_sense_pos} = '0;
    {regulation_ok, overvoltage_fault, zero_cross_1, pwm_high_req_1, pwm_high_req_2, pwm_low_req_1} = '0;
    goal_code = 7'h44;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    pwm_high_req_1 <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({high_side_drive_1, low_side_drive_1, high_side_drive_2, low_side_drive_2}, 0);
    pwm_high_req_1 <= 1'b0;
    for (i = 0; i < 3; i++) begin
      bus(1'b1, `TPBMSC_ADDR_CONFIG, wv[i]);
      rc(`TPBMSC_ADDR_CONFIG, ev[i]);
    end
    rc(8'h20, 0);
    rc(IV, BASE);
    run_cmd <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(1'b0, ST, 32'h0);
    chk({rd[10:8], rd[13:12]}, {3'd1, 2'b11});
    rc(IV, BASE * 8);
    step_gap(n);
    step_gap(n);
    chk(n, BASE * 8);
    wait_code(7'h40);
    repeat (3) @(posedge hclk);
    bus(1'b0, ST, 32'h0);
    chk({rd[10:8], rd[13]}, {3'd2, 1'b1});
    regulation_ok <= 1'b1;
    repeat (3) @(posedge hclk);
    bus(1'b0, ST, 32'h0);
    chk({rd[10:8], rd[13:12]}, {3'd3, 2'b01});
    rc(IV, BASE);
    wait_code(7'h44);
    chk(target_code, voltage_code);
    for (i = 0; i < 4; i++) begin
      sleep_cmd <= i[1];
      hint_cmd  <= i[0];
      repeat (8) @(posedge hclk);
      chk({skip_mode, phase2_active}, {i[1], !i[1] && i[0]});
    end
    stop_cmd <= 1'b1;
    repeat (4) @(posedge hclk);
    rc(IV, BASE * 4);
    chk({skip_mode, phase2_active}, 2'b10);
    stop_cmd <= 1'b0;
    repeat (4) @(posedge hclk);
    rc(IV, BASE);
    regulation_ok <= 1'b0;
    goal_code <= 7'h43;
    wait_code(7'h43);
    repeat (2) @(posedge hclk);
    chk({upper_pg_blank, ov_fixed_threshold, power_good_out}, 3'b111);
    sleep_cmd <= 1'b0;
    repeat (30) @(posedge hclk);
    chk(skip_mode, 1'b1);
    regulation_ok <= 1'b1;
    repeat (4) @(posedge hclk);
    chk({skip_mode, upper_pg_blank}, 2'b00);
    sleep_cmd <= 1'b1;
    zero_cross_1 <= 1'b1;
    pwm_low_req_1 <= 1'b1;
    repeat (4) @(posedge hclk);
    chk(low_side_drive_1, 1'b0);
    sleep_cmd <= 1'b0;
    repeat (8) @(posedge hclk);
    chk(low_side_drive_1, 1'b1);
    zero_cross_1 <= 1'b0;
    sleep_cmd <= 1'b1;
    repeat (4) @(posedge hclk);
    pwm_low_req_1 <= 1'b0;
    overvoltage_fault <= 1'b1;
    @(posedge hclk);
    overvoltage_fault <= 1'b0;
    repeat (3) @(posedge hclk);
    chk({high_side_drive_1, low_side_drive_1}, 2'b01);
    bus(1'b0, ST, 32'h0);
    chk(rd[16], 1'b1);
    shutdown_test_level <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({protect_disable, fault_latch_clear, overlap_disable, boost_switch_off}, 4'hf);
    bus(1'b0, ST, 32'h0);
    chk(rd[16], 1'b0);
    shutdown_test_level <= 1'b0;
    run_cmd <= 1'b0;
    repeat (4) @(posedge hclk);
    bus(1'b0, ST, 32'h0);
    chk({rd[10:8], rd[13]}, {3'd5, 1'b0});
    rc(IV, BASE * 8);
    // Second reset with phase 2 strapped off
    hresetn <= 1'b0;
    phase2_sense_pos <= 1'b1;
    run_cmd <= 1'b1;
    pwm_high_req_1 <= 1'b1;
    pwm_high_req_2 <= 1'b1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    bus(1'b0, ST, 32'h0);
    chk({rd[17], rd[13:12]}, 3'b110);
    chk({high_side_drive_1, high_side_drive_2}, 2'b10);
    results();
  end
endmodule

/* tpbmsc_consts.vh */
// Constants of the two-phase buck mode, phase and slew control block
// Included by every design file of the block by bare name; holds definitions only
//
// Behaviour
// - Normal rate scales 71.5k over resistor
// - Normal rate: skip entry/exit, boot-to-code move
// - One-eighth rate in startup and soft-shutdown
// - Sleep request plus stop hint: quarter rate
// - Follow stepped codes, never above normal rate
// - Phase-2 sense tied high disables phase 2
// - Shutdown holds all gate drives low
// - Overvoltage forces low sides of enabled phases high, beats limits
// - Skip mode: zero crossing turns low side off
// - Target from seven code inputs, host drives all
// - Shutdown release ramps to boot, eighth rate
// - Test level disables protection, clears fault latches
// - Sleep request high: immediate one-phase skip
// - Back to PWM when request low, regulated
// - Mode table from sleep request and hint
// - Forced two-phase modes in startup and transitions
// - Phase 2 strapped off: forced modes phase 1
// - Downward skip transition blanks upper power-good
// - Blanking swaps overvoltage threshold to fixed 1.8V
// - Power-good released while slewing plus 20us
// - Stop hint affects slew rate only

`ifndef TPBMSC_CONSTS_VH
`define TPBMSC_CONSTS_VH

// ==========================================================
// Timing
`define TPBMSC_CLK_MHZ          32'd250
`define TPBMSC_STEP_MV_X10      32'd125
`define TPBMSC_NORM_RATE_X10    32'd125
`define TPBMSC_REF_RES_X10      32'd715
`define TPBMSC_PG_HOLD_US       32'd20
`define TPBMSC_SHIFT_EIGHTH     3
`define TPBMSC_SHIFT_QUARTER    2

// ==========================================================
// Slew resistor range and reset value, units of 0.1 kohm
`define TPBMSC_RES_MIN_X10      11'd357
`define TPBMSC_RES_MAX_X10      11'd1780
`define TPBMSC_RES_RST_X10      11'd715

// ==========================================================
// Codes and thresholds
`define TPBMSC_BOOT_CODE        7'h40
`define TPBMSC_OFF_CODE         7'h00
`define TPBMSC_OV_MARGIN_MV     300
`define TPBMSC_OV_FIXED_MV      1800

// ==========================================================
// Register offsets and fields
`define TPBMSC_ADDR_CONFIG      8'h00
`define TPBMSC_ADDR_STATUS      8'h04
`define TPBMSC_ADDR_INTERVAL    8'h08
`define TPBMSC_HSIZE_WORD       3'h2
`define TPBMSC_CFG_RES_MSB      10
`define TPBMSC_STAT_STATE_LSB   8
`define TPBMSC_STAT_PH2         12
`define TPBMSC_STAT_SKIP        13
`define TPBMSC_STAT_PG          14
`define TPBMSC_STAT_BLANK       15
`define TPBMSC_STAT_OV          16
`define TPBMSC_STAT_PH2DIS      17
`define TPBMSC_STAT_SLEW        18

`endif

/* tpbmsc_ctrl.v */
// Mode, phase-count and slew sequencing of the two-phase buck controller
// Assumes an AHB-Lite master with one slave, and comparator inputs synchronous to hclk
`timescale 1ns/1ps
`include "tpbmsc_consts.vh"

module tpbmsc_ctrl #(
  parameter [31:0] PG_HOLD_CYCLES = `TPBMSC_PG_HOLD_US * `TPBMSC_CLK_MHZ
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  // Host power-state inputs
  input  wire [6:0]  voltage_code,
  input  wire        deeper_sleep_request,
  input  wire        power_state_hint_n,
  input  wire        deeper_stop_hint_n,
  input  wire        shutdown_n,
  input  wire        shutdown_test_level,
  // Straps and analog comparators
  input  wire        phase2_sense_pos,
  input  wire        regulation_ok,
  input  wire        overvoltage_fault,
  // Per-phase sensing and on-time requests
  input  wire        zero_cross_1,
  input  wire        zero_cross_2,
  input  wire        neg_limit_1,
  input  wire        neg_limit_2,
  input  wire        pwm_high_req_1,
  input  wire        pwm_high_req_2,
  input  wire        pwm_low_req_1,
  input  wire        pwm_low_req_2,
  // Gate drives
  output wire        high_side_drive_1,
  output wire        high_side_drive_2,
  output wire        low_side_drive_1,
  output wire        low_side_drive_2,
  // Status to the analog section
  output reg  [6:0]  target_code,
  output reg         power_good_out,
  output reg         phase2_active,
  output reg         skip_mode,
  output reg         upper_pg_blank,
  output wire        ov_fixed_threshold,
  // Test-level effects
  output wire        protect_disable,
  output wire        fault_latch_clear,
  output wire        overlap_disable,
  output wire        boost_switch_off
);

  localparam [2:0] ST_OFF   = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_BOOT  = 3'h2;
  localparam [2:0] ST_B2C   = 3'h3;
  localparam [2:0] ST_RUN   = 3'h4;
  localparam [2:0] ST_STOP  = 3'h5;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [10:0] slew_res;
  reg  [6:0]  code_q;
  reg  [12:0] iv_reg;
  reg  [12:0] next_iv;
  reg  [12:0] step_cnt;
  reg  [15:0] pg_hold;
  reg         skip_run;
  reg         ov_latched;
  reg         test_q;
  reg         ph2_dis;
  reg         strap_done;
  reg  [6:0]  goal;
  reg         next_skip;
  reg         next_ph2;
  reg         wr_pend;
  reg  [7:0]  wr_addr;
  reg  [31:0] read_mux;

  wire [31:0] rate_prod;
  wire [12:0] base_iv;
  wire        slewing;
  wire        step_now;
  wire        going_down;
  wire        bus_take;
  wire        cfg_write;
  wire [10:0] wr_res;
  wire [10:0] clamp_res;
  wire [31:0] status_word;

  // ==========================================================
  // AHB-Lite slave, zero wait states
  assign bus_take  = hsel & htrans[1] & hready;
  assign cfg_write = wr_pend & (wr_addr == `TPBMSC_ADDR_CONFIG);
  assign wr_res    = hwdata[`TPBMSC_CFG_RES_MSB:0];
  // Out-of-range resistor values are clamped, the rate formula only holds inside
  assign clamp_res = (wr_res < `TPBMSC_RES_MIN_X10) ? `TPBMSC_RES_MIN_X10 :
                     (wr_res > `TPBMSC_RES_MAX_X10) ? `TPBMSC_RES_MAX_X10 : wr_res;

  assign status_word = {13'h0000, slewing, ph2_dis, ov_latched, upper_pg_blank, power_good_out,
                        skip_mode, phase2_active, 1'b0, state, 1'b0, target_code};

  always @* begin
    read_mux = 32'h00000000;
    case (haddr[7:0])
      // Forward a pending write so back-to-back write then read sees new value
      `TPBMSC_ADDR_CONFIG:   read_mux = {21'h000000, cfg_write ? clamp_res : slew_res};
      `TPBMSC_ADDR_STATUS:   read_mux = status_word;
      `TPBMSC_ADDR_INTERVAL: read_mux = {19'h00000, iv_reg};
      default:               read_mux = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      slew_res  <= `TPBMSC_RES_RST_X10;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= bus_take & hwrite & (hsize == `TPBMSC_HSIZE_WORD);
      if (bus_take) begin
        wr_addr <= haddr[7:0];
      end
      if (bus_take & ~hwrite) begin
        hrdata <= read_mux;
      end
      if (cfg_write) begin
        slew_res <= clamp_res;
      end
    end
  end

  // ==========================================================
  // Slew interval: cycles per code step at the selected rate
  assign rate_prod = ({21'h000000, slew_res} * `TPBMSC_CLK_MHZ * `TPBMSC_STEP_MV_X10) /
                     (`TPBMSC_NORM_RATE_X10 * `TPBMSC_REF_RES_X10);
  assign base_iv   = rate_prod[12:0];

  always @* begin
    next_iv = base_iv;
    if ((state == ST_START) | (state == ST_STOP)) begin
      next_iv = base_iv << `TPBMSC_SHIFT_EIGHTH;
    end else if (deeper_sleep_request & deeper_stop_hint_n) begin
      next_iv = base_iv << `TPBMSC_SHIFT_QUARTER;
    end
  end

  // ==========================================================
  // Target stepping toward the goal of the current state
  always @* begin
    case (state)
      ST_START: goal = `TPBMSC_BOOT_CODE;
      ST_BOOT:  goal = `TPBMSC_BOOT_CODE;
      ST_B2C:   goal = code_q;
      ST_RUN:   goal = code_q;
      default:  goal = `TPBMSC_OFF_CODE;
    endcase
  end

  assign slewing    = (target_code != goal);
  assign step_now   = slewing & (step_cnt == 13'h0000);
  assign going_down = (goal < target_code);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iv_reg      <= 13'h0001;
      step_cnt    <= 13'h0000;
      target_code <= `TPBMSC_OFF_CODE;
      code_q      <= 7'h00;
    end else begin
      iv_reg <= next_iv;
      code_q <= voltage_code;
      // Restarting the count when idle caps the rate even for fast host steps
      if (!slewing | step_now) begin
        step_cnt <= iv_reg - 13'h0001;
      end else begin
        step_cnt <= step_cnt - 13'h0001;
      end
      if (step_now) begin
        target_code <= going_down ? target_code - 7'h01 : target_code + 7'h01;
      end
    end
  end

  // ==========================================================
  // Power sequencing
  always @* begin
    next_state = state;
    case (state)
      ST_OFF:   if (shutdown_n) next_state = ST_START;
      ST_START: if (!shutdown_n) next_state = ST_STOP;
        else if (target_code == `TPBMSC_BOOT_CODE) next_state = ST_BOOT;
      ST_BOOT:  if (!shutdown_n) next_state = ST_STOP;
        else if (regulation_ok) next_state = ST_B2C;
      ST_B2C:   if (!shutdown_n) next_state = ST_STOP;
        else if (target_code == code_q) next_state = ST_RUN;
      ST_RUN:   if (!shutdown_n) next_state = ST_STOP;
      ST_STOP:  if (target_code == `TPBMSC_OFF_CODE) next_state = ST_OFF;
      default:  next_state = ST_OFF;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Phase-2 strap, caught once on the first edge after reset release
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done <= 1'b0;
      ph2_dis    <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      ph2_dis    <= phase2_sense_pos;
    end
  end

  // ==========================================================
  // Operating mode and phase count
  always @* begin
    next_skip = 1'b0;
    next_ph2  = 1'b0;
    case (state)
      ST_START, ST_BOOT: begin
        next_skip = 1'b1;
        next_ph2  = ~ph2_dis;
      end
      ST_B2C, ST_STOP: begin
        next_skip = 1'b0;
        next_ph2  = ~ph2_dis;
      end
      ST_RUN: begin
        // Stop hint is deliberately absent here
        next_skip = skip_run | deeper_sleep_request;
        next_ph2  = ~ph2_dis & ~next_skip & power_state_hint_n;
      end
      default: begin
        next_skip = 1'b0;
        next_ph2  = 1'b0;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      skip_run      <= 1'b0;
      skip_mode     <= 1'b0;
      phase2_active <= 1'b0;
    end else begin
      if ((state != ST_RUN) | deeper_sleep_request) begin
        skip_run <= deeper_sleep_request;
      end else if (regulation_ok & ~slewing) begin
        skip_run <= 1'b0;
      end
      skip_mode     <= next_skip;
      phase2_active <= next_ph2;
    end
  end

  // ==========================================================
  // Power-good, blanking and fault latch
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pg_hold        <= 16'h0000;
      power_good_out <= 1'b0;
      upper_pg_blank <= 1'b0;
      ov_latched     <= 1'b0;
      test_q         <= 1'b0;
    end else begin
      test_q <= shutdown_test_level;
      if (slewing) begin
        pg_hold <= PG_HOLD_CYCLES[15:0];
      end else if (pg_hold != 16'h0000) begin
        pg_hold <= pg_hold - 16'h0001;
      end
      power_good_out <= (state == ST_RUN) & (slewing | (pg_hold != 16'h0000) | regulation_ok);
      // A new downward step wins over the clear
      if (step_now & going_down & skip_mode) begin
        upper_pg_blank <= 1'b1;
      end else if (~slewing & (pg_hold == 16'h0000) & regulation_ok) begin
        upper_pg_blank <= 1'b0;
      end
      if (overvoltage_fault & ~test_q) begin
        ov_latched <= 1'b1;
      end else if (test_q) begin
        ov_latched <= 1'b0;
      end
    end
  end

  assign ov_fixed_threshold = upper_pg_blank;
  assign protect_disable    = test_q;
  assign fault_latch_clear  = test_q;
  assign overlap_disable    = test_q;
  assign boost_switch_off   = test_q;

  // ==========================================================
  // Gate drives, one instance per phase
  tpbmsc_phase_drive u_phase1 (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .enable          (state != ST_OFF),
    .force_off       (state == ST_OFF),
    .ov_force        (ov_latched & ~test_q),
    .skip_mode       (skip_mode),
    .zero_cross      (zero_cross_1),
    .neg_limit       (neg_limit_1),
    .pwm_high_req    (pwm_high_req_1),
    .pwm_low_req     (pwm_low_req_1),
    .high_side_drive (high_side_drive_1),
    .low_side_drive  (low_side_drive_1)
  );

  tpbmsc_phase_drive u_phase2 (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .enable          (phase2_active),
    .force_off       (state == ST_OFF),
    .ov_force        (ov_latched & ~test_q & ~ph2_dis),
    .skip_mode       (skip_mode),
    .zero_cross      (zero_cross_2),
    .neg_limit       (neg_limit_2),
    .pwm_high_req    (pwm_high_req_2),
    .pwm_low_req     (pwm_low_req_2),
    .high_side_drive (high_side_drive_2),
    .low_side_drive  (low_side_drive_2)
  );

endmodule

/* tpbmsc_ctrl_properties.sv */
// Concurrent checks on the ports of the mode, phase and slew control block
// Assumes one hclk domain; bound into every tpbmsc_ctrl instance below
`timescale 1ns/1ps

module tpbmsc_ctrl_props #(
  parameter [31:0] PG_HOLD_CYCLES = 32'd5000
) (
  // Clock and reset
  input wire       hclk,
  input wire       hresetn,
  // Host and comparator levels
  input wire       deeper_sleep_request,
  input wire       power_state_hint_n,
  input wire       shutdown_n,
  input wire       shutdown_test_level,
  input wire       regulation_ok,
  input wire       overvoltage_fault,
  // Watched outputs
  input wire       high_side_drive_1,
  input wire       low_side_drive_1,
  input wire [6:0] target_code,
  input wire       power_good_out,
  input wire       phase2_active,
  input wire       skip_mode,
  input wire       upper_pg_blank,
  input wire       ov_fixed_threshold,
  input wire       protect_disable,
  input wire       fault_latch_clear,
  input wire       overlap_disable,
  input wire       boost_switch_off
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ==========================================================
  // Drives and protection
  // Skip mode proves a startup, boot or run state, so phase 1 stays enabled
  AST_OV_LOW_SIDE: assert property (
    overvoltage_fault && !protect_disable && skip_mode && $past(shutdown_n) ##1 !protect_disable
    |=> low_side_drive_1 && !high_side_drive_1) else $error("low side not forced by overvoltage");
  AST_TEST_LEVEL: assert property (
    {protect_disable, fault_latch_clear, overlap_disable, boost_switch_off} == {4{$past(shutdown_test_level)}})
    else $error("test level outputs wrong");

  // ==========================================================
  // Power-good and blanking
  AST_SKIP_DOWN_BLANK: assert property (
    $past(skip_mode) && target_code < $past(target_code) |-> ##[0:1] (upper_pg_blank && ov_fixed_threshold))
    else $error("no blanking on downward skip step");
  AST_PG_WHILE_SLEW: assert property (
    power_good_out && $past(shutdown_n) && target_code != $past(target_code) |=> power_good_out)
    else $error("power good dropped while slewing");

  // ==========================================================
  // Mode selection
  AST_SLEEP_SKIP: assert property (
    $rose(deeper_sleep_request) && power_good_out && $past(shutdown_n) |=> skip_mode)
    else $error("sleep request did not enter skip");
  AST_SKIP_HOLD: assert property (
    power_good_out && $past(shutdown_n) && skip_mode && !regulation_ok && !$past(regulation_ok) |=> skip_mode)
    else $error("left skip before regulation");
  AST_HINT_ONE_PHASE: assert property (
    !power_state_hint_n && power_good_out && $past(shutdown_n) |=> !phase2_active)
    else $error("phase 2 on with hint low");

  // ==========================================================
  // Target stepping
  AST_ONE_STEP: assert property (
    target_code != $past(target_code) |-> (target_code - $past(target_code) == 7'h01
    || $past(target_code) - target_code == 7'h01)) else $error("target moved more than one step");
  AST_STEP_SPACING: assert property (
    target_code != $past(target_code) |=> $stable(target_code) [*8]) else $error("target steps too close");

  CP_SLEEP_ENTRY: cover property ($rose(deeper_sleep_request) && power_good_out);
  CP_BLANK: cover property ($rose(upper_pg_blank));
  CP_OV: cover property (overvoltage_fault && skip_mode);
endmodule

bind tpbmsc_ctrl tpbmsc_ctrl_props #(.PG_HOLD_CYCLES(PG_HOLD_CYCLES)) i_props (
  .hclk, .hresetn, .deeper_sleep_request, .power_state_hint_n, .shutdown_n, .shutdown_test_level, .regulation_ok,
  .overvoltage_fault, .high_side_drive_1, .low_side_drive_1, .target_code, .power_good_out,
  .phase2_active, .skip_mode, .upper_pg_blank, .ov_fixed_threshold, .protect_disable,
  .fault_latch_clear, .overlap_disable, .boost_switch_off);

/* tpbmsc_host_model.sv */
// Host model: drives the voltage code and power-state levels
// Assumes bench commands change just after a rising hclk edge
`timescale 1ns/1ps

module tpbmsc_host_model #(
  parameter [6:0]  INIT_CODE = 7'h44,
  parameter [15:0] STEP_GAP  = 16'h00c8
) (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Bench commands
  input  wire [6:0] goal_code,
  input  wire       sleep_cmd,
  input  wire       hint_cmd,
  input  wire       stop_cmd,
  input  wire       run_cmd,
  // Levels to the controller
  output reg  [6:0] voltage_code,
  output reg        deeper_sleep_request,
  output reg        power_state_hint_n,
  output reg        deeper_stop_hint_n,
  output reg        shutdown_n
);
  reg [15:0] gap;

  // All code bits always driven: the inputs have no pull-ups
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      voltage_code         <= INIT_CODE;
      deeper_sleep_request <= 1'b0;
      power_state_hint_n   <= 1'b0;
      deeper_stop_hint_n   <= 1'b0;
      shutdown_n           <= 1'b0;
      gap                  <= 16'h0000;
    end else begin
      deeper_sleep_request <= sleep_cmd;
      power_state_hint_n   <= hint_cmd;
      deeper_stop_hint_n   <= stop_cmd;
      shutdown_n           <= run_cmd;
      gap                  <= (gap == 16'h0000) ? STEP_GAP : gap - 16'h0001;
      // Clocked code, one step per gap, slower than the normal rate only near the minimum resistor
      if (gap == 16'h0000 && voltage_code != goal_code) begin
        voltage_code <= (voltage_code < goal_code) ? voltage_code + 7'h01 : voltage_code - 7'h01;
      end
    end
  end
endmodule

/* tpbmsc_phase_drive.v */
// Gate-drive forcing for one converter phase
// Assumes the on-time logic supplies high and low requests synchronous to hclk
`timescale 1ns/1ps
`include "tpbmsc_consts.vh"

module tpbmsc_phase_drive (
  // Clock and reset
  input  wire hclk,
  input  wire hresetn,
  // Control
  input  wire enable,
  input  wire force_off,
  input  wire ov_force,
  input  wire skip_mode,
  // Phase sensing and timing requests
  input  wire zero_cross,
  input  wire neg_limit,
  input  wire pwm_high_req,
  input  wire pwm_low_req,
  // Gate drives
  output reg  high_side_drive,
  output reg  low_side_drive
);

  reg zc_seen;
  reg next_high;
  reg next_low;

  // ==========================================================
  // Zero-crossing memory, a new high-side pulse clears it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zc_seen <= 1'b0;
    end else if (skip_mode & zero_cross) begin
      zc_seen <= 1'b1;
    end else if (pwm_high_req | ~skip_mode) begin
      zc_seen <= 1'b0;
    end
  end

  // ==========================================================
  // Priority: off, overvoltage, zero crossing, limits, normal
  always @* begin
    next_high = 1'b0;
    next_low  = 1'b0;
    if (force_off | ~enable) begin
      next_high = 1'b0;
      next_low  = 1'b0;
    end else if (ov_force) begin
      next_low  = 1'b1;
    end else if (skip_mode & (zc_seen | zero_cross)) begin
      next_high = pwm_high_req;
      next_low  = 1'b0;
    end else begin
      next_high = pwm_high_req;
      // Never both sides on, shoot-through would short the input
      next_low  = pwm_low_req & ~pwm_high_req & ~neg_limit;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_side_drive <= 1'b0;
      low_side_drive  <= 1'b0;
    end else begin
      high_side_drive <= next_high;
      low_side_drive  <= next_low;
    end
  end

endmodule
